// ===== hdl/bslu_pkg.sv
/*
  bslu_pkg: shared constants and types for the bitwise string logic unit.
  Assumes a word-addressed data memory of sixteen-bit words and a
  program sequencer that starts one operation per scan.
*/
package bslu_pkg;

    // data word and string geometry
    localparam int BSLU_WORD_W     = 16;
    localparam int BSLU_MAX_WORDS  = 256;
    localparam int BSLU_ADDR_W_DEF = 16;

    // logic functions selectable per operation
    typedef enum logic [1:0] {
        BSLU_OP_AND = 2'h0,
        BSLU_OP_OR  = 2'h1,
        BSLU_OP_XOR = 2'h2,
        BSLU_OP_NOT = 2'h3
    } bslu_op_t;

    // sequencing states, one-hot
    typedef enum logic [6:0] {
        BSLU_S_IDLE = 7'h01,
        BSLU_S_ISA  = 7'h02,
        BSLU_S_ISB  = 7'h04,
        BSLU_S_GETA = 7'h08,
        BSLU_S_GETB = 7'h10,
        BSLU_S_WR   = 7'h20,
        BSLU_S_FIN  = 7'h40
    } bslu_state_t;

    // reset values of the status outputs
    localparam logic BSLU_OK_RST   = 1'b0;
    localparam logic BSLU_DONE_RST = 1'b0;
    localparam logic BSLU_BUSY_RST = 1'b0;

endpackage

// ===== hdl/bslu_word_op.sv
/*
  bslu_word_op: combinational bitwise function over one data word.
  Assumes operands are already registered by the caller; result is
  registered by the caller before it reaches the memory.
*/
`timescale 1ns/1ps
module bslu_word_op
    import bslu_pkg::*;
#(
    parameter int W = BSLU_WORD_W
) (
    // function select
    input  wire bslu_op_t  op,
    // paired operand words
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    // result word
    output wire logic [W-1:0] y
);

    // elaboration check on the word width
    if (W < 1) begin : g_bad_w
        $error("bslu_word_op: W must be at least 1");
    end

    // each result bit pairs same-position operand bits, lsb upward
    for (genvar i = 0; i < W; i++) begin : g_bit
        wire logic and_b = a[i] & b[i];                 // [RL3] [RL5]
        wire logic or_b  = a[i] | b[i];                 // [RL4]
        wire logic xor_b = a[i] ^ b[i];                 // [RL6]
        wire logic not_b = ~a[i];                       // [RL8]
        assign y[i] = (op == BSLU_OP_AND) ? and_b :
                      (op == BSLU_OP_OR)  ? or_b  :
                      (op == BSLU_OP_XOR) ? xor_b : not_b;  // [RL1]
    end

endmodule // bslu_word_op

// ===== hdl/bslu_top.sv
/*
  bslu_top: bitwise string logic unit (AND, OR, XOR, NOT) over strings of
  up to MAX_WORDS sixteen-bit words, walked word by word through memory.
  Assumes one clock, a single-port synchronous word memory that samples
  mem_rd/mem_wr at a clock edge and presents read data for the next edge,
  and a sequencer on the same clock that pulses start once per scan.
*/
// What this block does
// (RL1) pair each first-operand bit with same-position second-operand bit, lsb first
// (RL2) strings span a chosen length up to 256 words, all processed
// (RL3) and: result 1 only when both paired bits are 1
// (RL4) or: result 1 when either paired bit is 1
// (RL5) and stays correct when the two operand strings overlap in memory
// (RL6) xor: result 1 when exactly one paired bit is 1
// (RL7) xor into the second operand toggles bits each enabled scan
// (RL8) not rewrites every result bit as complement of operand bit
// (RL9) ok asserted whenever enable is asserted, never withheld by errors
// (RL10) each operand is an immediate word or a memory string start
// (RL11) configuring party must not target the plain system status area
// (RL12) multi-word string is one bit sequence, word 0 bit 0 is lsb
// (RL13) configuring party should avoid overlapping input and output ranges
// (RL14) disabled scan leaves the result untouched and ok low
// (RL15) whole result string is written before done is given
`timescale 1ns/1ps
module bslu_top
    import bslu_pkg::*;
#(
    parameter int ADDR_W    = BSLU_ADDR_W_DEF,
    parameter int MAX_WORDS = BSLU_MAX_WORDS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // scan control from the sequencer
    input  wire logic              start,
    input  wire logic              enable,
    input  wire bslu_op_t          op,
    input  wire logic [$clog2(MAX_WORDS)-1:0] len_m1,
    // first operand string
    input  wire logic              first_operand_string_is_mem,
    input  wire logic [ADDR_W-1:0] first_operand_string_base,
    input  wire logic [BSLU_WORD_W-1:0] first_operand_string_imm,
    // second operand string
    input  wire logic              second_operand_string_is_mem,
    input  wire logic [ADDR_W-1:0] second_operand_string_base,
    input  wire logic [BSLU_WORD_W-1:0] second_operand_string_imm,
    // result string
    input  wire logic [ADDR_W-1:0] result_string_base,
    // status back to the sequencer
    output logic                   ok,
    output logic                   done,
    output logic                   busy,
    // data memory port
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [BSLU_WORD_W-1:0] mem_wdata,
    input  wire logic [BSLU_WORD_W-1:0] mem_rdata
);

    localparam int LEN_W = $clog2(MAX_WORDS);
    localparam int W     = BSLU_WORD_W;

    // elaboration checks on geometry
    if (MAX_WORDS < 2 || (1 << LEN_W) != MAX_WORDS) begin : g_bad_len
        $error("bslu_top: MAX_WORDS must be a power of two, at least 2");
    end
    if (ADDR_W < LEN_W) begin : g_bad_addr
        $error("bslu_top: ADDR_W too small to span a full string");
    end

    // sequencing state
    bslu_state_t       state_q;
    bslu_state_t       state_d;

    // operation captured at start
    bslu_op_t          op_q;
    logic [LEN_W-1:0]  len_q;
    logic [LEN_W-1:0]  cnt_q;
    logic              a_mem_q;
    logic              b_mem_q;
    logic [ADDR_W-1:0] a_base_q;
    logic [ADDR_W-1:0] b_base_q;
    logic [ADDR_W-1:0] q_base_q;
    logic [W-1:0]      a_imm_q;
    logic [W-1:0]      b_imm_q;

    // current word pair
    logic [W-1:0]      a_word_q;
    logic [W-1:0]      b_word_q;
    wire  logic [W-1:0] res_word;

    // output registers
    logic              ok_q;
    logic              done_q;
    logic              busy_q;
    logic              mem_rd_q;
    logic              mem_wr_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [W-1:0]      mem_wdata_q;

    // next values of the output registers
    logic              ok_d;
    logic              done_d;
    logic              busy_d;
    logic              mem_rd_d;
    logic              mem_wr_d;
    logic [ADDR_W-1:0] mem_addr_d;
    logic [W-1:0]      mem_wdata_d;

    // state decode
    wire logic st_idle = (state_q == BSLU_S_IDLE);
    wire logic st_isa  = (state_q == BSLU_S_ISA);
    wire logic st_isb  = (state_q == BSLU_S_ISB);
    wire logic st_geta = (state_q == BSLU_S_GETA);
    wire logic st_getb = (state_q == BSLU_S_GETB);
    wire logic st_wr   = (state_q == BSLU_S_WR);
    wire logic st_fin  = (state_q == BSLU_S_FIN);

    // start acceptance; a start while busy is ignored
    // a refused start raises nothing: no done answers it, so the
    // sequencer waits for done before it asks again
    wire logic take_start = st_idle & start;
    wire logic take_run   = take_start & enable;
    wire logic take_skip  = take_start & ~enable;              // [RL14]

    // invert uses only the first operand
    wire logic use_b     = (op_q != BSLU_OP_NOT);
    wire logic last_word = (cnt_q == len_q);                   // [RL2]

    // read requests only for operands that live in memory
    wire logic rd_a = st_isa & a_mem_q;                        // [RL10]
    wire logic rd_b = st_isb & b_mem_q & use_b;                // [RL10]

    // word addresses: string word k sits at base + k, word 0 holds the lsb
    wire logic [ADDR_W-1:0] cnt_ext = ADDR_W'(cnt_q);
    wire logic [ADDR_W-1:0] addr_a  = a_base_q + cnt_ext;      // [RL12]
    wire logic [ADDR_W-1:0] addr_b  = b_base_q + cnt_ext;      // [RL12]
    wire logic [ADDR_W-1:0] addr_q  = q_base_q + cnt_ext;      // [RL12]

    // operand words: memory data or the immediate reused for every word
    wire logic [W-1:0] a_next = a_mem_q ? mem_rdata : a_imm_q; // [RL10]
    wire logic [W-1:0] b_next = b_mem_q ? mem_rdata : b_imm_q; // [RL10]

    // memory port next values; reads of a word precede its write
    assign mem_rd_d    = rd_a | rd_b;
    assign mem_wr_d    = st_wr;                                // [RL7] [RL8]
    assign mem_addr_d  = rd_a  ? addr_a :
                         rd_b  ? addr_b :
                         st_wr ? addr_q : mem_addr_q;
    assign mem_wdata_d = st_wr ? res_word : mem_wdata_q;

    // status next values
    assign done_d = st_fin | take_skip;                        // [RL15]
    assign busy_d = take_run | (busy_q & ~st_fin);
    assign ok_d   = take_start ? 1'b0 :
                    st_fin     ? 1'b1 : ok_q;                  // [RL9] [RL14]

    // word function
    bslu_word_op #(
        .W  (W)
    ) u_word_op (
        .op (op_q),
        .a  (a_word_q),
        .b  (b_word_q),
        .y  (res_word)
    );

    // state sequencing, one word per pass through isa..wr
    // both operand words are read before their result is written, so a result
    // aimed at the second operand still sees the old word (xor toggling), and
    // overlapping operand strings only ever read words that are not yet rewritten
    always_comb begin
        state_d = state_q;
        case (state_q)
            BSLU_S_IDLE: begin
                if (take_run) begin
                    state_d = BSLU_S_ISA;
                end
            end
            BSLU_S_ISA:  state_d = BSLU_S_ISB;
            BSLU_S_ISB:  state_d = BSLU_S_GETA;
            BSLU_S_GETA: state_d = BSLU_S_GETB;
            BSLU_S_GETB: state_d = BSLU_S_WR;
            BSLU_S_WR: begin
                if (last_word) begin
                    state_d = BSLU_S_FIN;                      // [RL2] [RL15]
                end else begin
                    state_d = BSLU_S_ISA;
                end
            end
            BSLU_S_FIN:  state_d = BSLU_S_IDLE;
            default:     state_d = BSLU_S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= BSLU_S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // capture of the operation at an enabled start
    // the sequencer may change its inputs once start is taken, so every
    // operand selection is frozen here for the whole string
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            op_q     <= BSLU_OP_AND;
            len_q    <= '0;
            a_mem_q  <= 1'b0;
            b_mem_q  <= 1'b0;
            a_base_q <= '0;
            b_base_q <= '0;
            q_base_q <= '0;
            a_imm_q  <= '0;
            b_imm_q  <= '0;
        end else if (take_run) begin
            op_q     <= op;
            len_q    <= len_m1;                                // [RL2]
            a_mem_q  <= first_operand_string_is_mem;
            b_mem_q  <= second_operand_string_is_mem;
            a_base_q <= first_operand_string_base;
            b_base_q <= second_operand_string_base;
            q_base_q <= result_string_base;
            a_imm_q  <= first_operand_string_imm;
            b_imm_q  <= second_operand_string_imm;
        end
    end

    // word counter walks the string from the lowest word upward
    // the counter stops at the last word, so no write lands past the string
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (take_run) begin
            cnt_q <= '0;                                       // [RL12]
        end else if (st_wr && !last_word) begin
            cnt_q <= cnt_q + LEN_W'(1);                        // [RL2]
        end
    end

    // operand words are latched from memory one cycle after each read
    // an immediate operand skips its read slot; the immediate word is reused
    // for every word of the string
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            a_word_q <= '0;
            b_word_q <= '0;
        end else begin
            if (st_geta) begin
                a_word_q <= a_next;                            // [RL5]
            end
            if (st_getb) begin
                b_word_q <= use_b ? b_next : '0;               // [RL5]
            end
        end
    end

    // memory port registers
    // address and data hold between strobes; the memory looks at them
    // only while mem_rd or mem_wr is high
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mem_rd_q    <= 1'b0;
            mem_wr_q    <= 1'b0;
            mem_addr_q  <= '0;
            mem_wdata_q <= '0;
        end else begin
            mem_rd_q    <= mem_rd_d;
            mem_wr_q    <= mem_wr_d;
            mem_addr_q  <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // status registers
    // ok is a level: it drops at every taken start and rises with done only
    // for an enabled operation, so a disabled scan reads back ok low
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ok_q   <= BSLU_OK_RST;
            done_q <= BSLU_DONE_RST;
            busy_q <= BSLU_BUSY_RST;
        end else begin
            ok_q   <= ok_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    // outputs straight from flops
    // no logic sits behind any output, so the sequencer sees clean levels
    assign ok        = ok_q;
    assign done      = done_q;
    assign busy      = busy_q;
    assign mem_rd    = mem_rd_q;
    assign mem_wr    = mem_wr_q;
    assign mem_addr  = mem_addr_q;
    assign mem_wdata = mem_wdata_q;

endmodule // bslu_top

// ===== verif/bslu_top_sva.sv
/*
  bslu_top_sva: timing checks on the status and memory strobes of bslu_top.
  Assumes one clock clk_sys and the synchronous active-low reset rstn.
*/
`timescale 1ns/1ps
module bslu_top_sva
    import bslu_pkg::*;
#(
    parameter int ADDR_W    = BSLU_ADDR_W_DEF,
    parameter int MAX_WORDS = BSLU_MAX_WORDS
) (
    // clock, reset and request
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire logic enable,
    // status and memory strobes
    input wire logic ok,
    input wire logic done,
    input wire logic busy,
    input wire logic mem_rd,
    input wire logic mem_wr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [15:0] run_q;
    // counts the busy cycles of the running operation
    always_ff @(posedge clk_sys) begin
        if (!rstn || !busy) run_q <= 16'h0;
        else run_q <= run_q + 16'h1;
    end
    ok_low_busy_a: assert property (busy |-> !ok) else $error("ok high while busy");
    disabled_scan_a: assert property (start && !busy && !enable |=> done && !ok && !mem_rd && !mem_wr)
        else $error("disabled scan misbehaved");
    enabled_take_a: assert property (start && !busy && enable |=> busy && !ok)
        else $error("enabled start not taken");
    finish_ok_a: assert property ($fell(busy) |-> done && ok) else $error("ok withheld at finish");
    rw_exclusive_a: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
    access_busy_a: assert property (mem_rd || mem_wr |-> busy) else $error("memory access while idle");
    done_pulse_a: assert property (done && !start |=> !done) else $error("done longer than one cycle");
    write_first_a: assert property (done && ok |-> $past(mem_wr)) else $error("done before last write");
    length_cap_a: assert property (run_q < 5 * MAX_WORDS + 2) else $error("operation too long");
    ok_hold_a: assert property (!busy && !start |=> $stable(ok)) else $error("ok changed while idle");
    en_done_c: cover property (done && ok);
    dis_done_c: cover property (done && !ok);
    write_c: cover property (mem_wr);
endmodule // bslu_top_sva

bind bslu_top bslu_top_sva #(.ADDR_W(ADDR_W), .MAX_WORDS(MAX_WORDS)) sva_u (.clk_sys(clk_sys), .rstn(rstn),
    .start(start), .enable(enable), .ok(ok), .done(done), .busy(busy), .mem_rd(mem_rd), .mem_wr(mem_wr));

// ===== verif/bslu_mem_model.sv
/*
  bslu_mem_model: word data memory facing bslu_top, one-cycle read answer.
  Assumes strobes on clk_sys; the read line scrambles when no read is due.
*/
`timescale 1ns/1ps
module bslu_mem_model
    import bslu_pkg::*;
(
    // clock and request
    input  wire logic                   clk_sys,
    input  wire logic                   mem_rd,
    input  wire logic                   mem_wr,
    input  wire logic [15:0]            mem_addr,
    input  wire logic [BSLU_WORD_W-1:0] mem_wdata,
    // read answer
    output logic [BSLU_WORD_W-1:0]      mem_rdata
);
    logic [BSLU_WORD_W-1:0] mem [0:1023];
    initial mem_rdata = 16'h0;
    // stale read data never lingers, so a late latch is caught
    always @(posedge clk_sys) begin
        if (mem_wr) mem[mem_addr[9:0]] <= mem_wdata;
        mem_rdata <= mem_rd ? mem[mem_addr[9:0]] : ~mem_rdata;
    end
endmodule // bslu_mem_model

// ===== verif/testbench.sv
/*
  testbench: drives scans into bslu_top and checks every write and done.
  Assumes bslu_mem_model as data memory and the bound checker.
*/
`timescale 1ns/1ps
module testbench
    import bslu_pkg::*;
;
    logic        clk_sys = 0, rstn = 0, start = 0, enable = 0, a_mem = 0, b_mem = 0;
    bslu_op_t    op = BSLU_OP_AND;
    logic [7:0]  len_m1 = 0;
    logic [15:0] a_base = 0, b_base = 0, a_imm = 0, b_imm = 0, q_base = 0;
    wire         ok, done, busy, mem_rd, mem_wr;
    wire  [15:0] mem_addr, mem_wdata, mem_rdata;
    int          error_cnt = 0, checks = 0, cyc = 0;
    logic [15:0] mir [0:1023];
    logic [32:0] exp_q [$];

    bslu_top dut_u (.clk_sys, .rstn, .start, .enable, .op, .len_m1, .first_operand_string_is_mem(a_mem),
        .first_operand_string_base(a_base), .first_operand_string_imm(a_imm),
        .second_operand_string_is_mem(b_mem), .second_operand_string_base(b_base),
        .second_operand_string_imm(b_imm), .result_string_base(q_base), .ok, .done, .busy,
        .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
    bslu_mem_model mem_u (.clk_sys, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

    always #5 clk_sys = ~clk_sys;

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // notes the expected writes word by word in memory order, then starts the scan
    task automatic run(input bslu_op_t o, input logic en, input logic [7:0] n, input logic am,
        input logic [15:0] ab, ai, input logic bm, input logic [15:0] bb, bi, qb);
        logic [15:0] x, y, r;
        for (int k = 0; k <= n && en; k++) begin
            x = am ? mir[10'(ab + k)] : ai;
            y = bm ? mir[10'(bb + k)] : bi;
            case (o)
                BSLU_OP_AND: r = x & y;
                BSLU_OP_OR:  r = x | y;
                BSLU_OP_XOR: r = x ^ y;
                default:     r = ~x;
            endcase
            mir[10'(qb + k)] = r;
            exp_q.push_back({1'b0, 16'(qb + k), r});
        end
        exp_q.push_back({1'b1, 31'h0, en});
        @(negedge clk_sys);
        {op, enable, len_m1, a_mem, a_base, a_imm, b_mem, b_base, b_imm, q_base} =
            {o, en, n, am, ab, ai, bm, bb, bi, qb};
        start = 1;
        @(negedge clk_sys);
        start = 0;
        while (done !== 1'b1) @(negedge clk_sys);
    endtask

    // compares each write or done against the oldest note; also bounds the run
    always @(posedge clk_sys) begin
        cyc++;
        if (rstn && (mem_wr || done))
            check(done ? {1'b1, 31'h0, ok} : {1'b0, mem_addr, mem_wdata},
                  exp_q.size() ? exp_q.pop_front() : 'x);
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        void'($urandom(32'hdc8a5f4c));
        for (int i = 0; i < 1024; i++) begin
            mir[i] = 16'($urandom);
            mem_u.mem[i] = mir[i];
        end
        repeat (8) @(negedge clk_sys);
        rstn = 1;
        check({ok, done, busy, mem_rd, mem_wr, mem_addr, mem_wdata}, 40'h0);
        // all functions, operand kinds and short lengths; results kept clear of inputs
        for (int i = 0; i < 24; i++)
            run(bslu_op_t'(i % 4), i % 6 != 5, 8'($urandom_range(7)), 1'($urandom), 16'($urandom_range(503)),
                16'($urandom), 1'($urandom), 16'($urandom_range(503)), 16'($urandom),
                16'($urandom_range(767, 512)));
        run(BSLU_OP_AND, 1, 8'hff, 1, 16'h0, 16'h0, 1, 16'h100, 16'h0, 16'h200);
        run(BSLU_OP_AND, 1, 8'h3, 1, 16'h10, 16'h0, 1, 16'h11, 16'h0, 16'h300);
        repeat (2) run(BSLU_OP_XOR, 1, 8'h1, 1, 16'h20, 16'h0, 1, 16'h380, 16'h0, 16'h380);
        repeat (4) @(negedge clk_sys);
        check(exp_q.size(), 40'h0);
        finish_test();
    end
endmodule // testbench
